// *** mmut_params.svh ***
// Constants for the address translation unit: widths, counts, encodings and bit positions.
`ifndef MMUT_PARAMS_SVH
`define MMUT_PARAMS_SVH
`define MMUT_VA_W 32
`define MMUT_OFS_W 12
`define MMUT_VPN_W 20
`define MMUT_TAG_W 8
`define MMUT_UTLB_ENTRIES 10
`define MMUT_MAIN_ENTRIES 128
`define MMUT_MAIN_WAYS 2
`define MMUT_SET_W 6
`define MMUT_RR_W 4
`define MMUT_WA_STREAK 3
`define MMUT_STREAK_W 3
`define MMUT_SPLIT_BIT 31
`define MMUT_SZ_4K 2'h0
`define MMUT_SZ_64K 2'h1
`define MMUT_SZ_1M 2'h2
`define MMUT_SZ_16M 2'h3
`define MMUT_SH_4K 0
`define MMUT_SH_64K 4
`define MMUT_SH_1M 8
`define MMUT_SH_16M 12
`define MMUT_NUM_SIZES 4
`define MMUT_MT_STRONG 2'h0
`define MMUT_MT_DEVICE 2'h1
`define MMUT_MT_NORMAL 2'h2
`define MMUT_SHR_NONE 2'h0
`define MMUT_SHR_INNER 2'h1
`define MMUT_SHR_OUTER 2'h2
`define MMUT_POL_NC 2'h0
`define MMUT_POL_WT 2'h1
`define MMUT_POL_WBWA 2'h2
`define MMUT_POL_WBNA 2'h3
`endif

// *** mmut_pkg.sv ***
// Types shared by the translation unit and its entry memory.
`include "mmut_params.svh"
`default_nettype none
package mmut_pkg;
  typedef struct packed {
    logic [`MMUT_VPN_W-1:0] vpn;
    logic [`MMUT_VPN_W-1:0] ppn;
    logic [1:0] size;
    logic [`MMUT_TAG_W-1:0] tag;
    logic glob;
    logic ns;
    logic [1:0] mtype;
    logic [1:0] share;
    logic [1:0] pol;
  } mmut_entry_t;
  typedef struct packed {
    logic [1:0] mtype;
    logic [1:0] share;
    logic [1:0] pol;
    logic bypass;
  } mmut_attr_t;
  typedef enum logic [4:0] {
    MMUT_IDLE = 5'b0_0001,
    MMUT_READ = 5'b0_0010,
    MMUT_CMP = 5'b0_0100,
    MMUT_WALK = 5'b0_1000,
    MMUT_FILL = 5'b1_0000
  } mmut_state_t;
endpackage
`default_nettype wire

// *** mmut_ram_if.sv ***
// Port bundle between the walk controller and the main entry memory.
`default_nettype none
interface mmut_ram_if #(parameter int DW = 58, parameter int WAYS = 2, parameter int SET_W = 6);
  logic rd_en;
  logic [SET_W-1:0] rd_idx;
  logic [WAYS*DW-1:0] rd_data;
  logic wr_en;
  logic wr_way;
  logic [SET_W-1:0] wr_idx;
  logic [DW-1:0] wr_data;
  modport ctrl (output rd_en, output rd_idx, input rd_data, output wr_en, output wr_way, output wr_idx,
    output wr_data);
  modport mem (input rd_en, input rd_idx, output rd_data, input wr_en, input wr_way, input wr_idx,
    input wr_data);
endinterface
`default_nettype wire

// *** mmut_tlb_ram.sv ***
// Main translation entry memory: sets of ways with registered read data.
`default_nettype none
module mmut_tlb_ram #(
  parameter int DW = 58,
  parameter int WAYS = 2,
  parameter int SET_W = 6
) (
  input wire logic clk,
  mmut_ram_if.mem ram
);
  // The array has no reset so that its contents survive dormant mode.
  genvar w;
  generate
    for (w = 0; w < WAYS; w++) begin : g_way
      logic [DW-1:0] mem [0:(1<<SET_W)-1];
      logic [DW-1:0] rd_reg;
      always_ff @(posedge clk) begin
        if (ram.wr_en && (ram.wr_way == w[0])) begin
          mem[ram.wr_idx] <= ram.wr_data;
        end
        if (ram.rd_en) begin
          rd_reg <= mem[ram.rd_idx];
        end
      end
      assign ram.rd_data[w*DW +: DW] = rd_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// *** mmut_tlb.sv ***
// Two-level address translation with first-level and main TLBs and memory attribute resolution.
`include "mmut_params.svh"
`default_nettype none
// Notes on behaviour
// - Every core virtual address is translated to a physical address with its attributes.
// - Separate small first-level TLBs serve instruction fetch and data accesses.
// - A first-level miss requests the single main TLB shared by both sides.
// - The main TLB is a 128-entry two-way set-associative RAM.
// - Page walks may fetch descriptors from the L1 data cache.
// - Walk cacheability is chosen per table base and applies to all its walks.
// - A hitmap of stored page sizes is readable and writable by software.
// - Main TLB RAM contents are kept across dormant state.
// - Entries map 16MB, 1MB, 64KB or 4KB granules.
// - Entries are global or tagged with an address space tag.
// - Write-through regions are handled as non-cacheable.
// - Outer-shareable regions are handled as inner-shareable.
// - Write-back no-allocate becomes write-back write-allocate.
// - Non-shareable non-cacheable Normal accesses bypass the L1 caches.
// - Write allocation stops after more than three back to back full-line writes to non-shareable regions.
// - Inner-shareable write-through Normal is inner-shareable non-cacheable.
// - Inner-shareable write-back is non-cacheable unless coherency bit set, then WBWA.
// - Outer-shareable write-back follows the same coherency-bit choice.
// - Each first-level TLB holds 10 entries and looks up in one cycle.
// - A hit needs address, security state and tag or global to match.
module mmut_tlb
  import mmut_pkg::*;
#(
  parameter int UTLB_N = `MMUT_UTLB_ENTRIES,
  parameter int MAIN_N = `MMUT_MAIN_ENTRIES,
  parameter int WAYS = `MMUT_MAIN_WAYS,
  parameter int SET_W = `MMUT_SET_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ifetch_req,
  input wire logic [`MMUT_VA_W-1:0] ifetch_va,
  output logic ifetch_ready,
  output logic ifetch_rsp_valid,
  output logic [`MMUT_VA_W-1:0] ifetch_pa,
  output logic [1:0] ifetch_mem_type,
  output logic [1:0] ifetch_share,
  output logic [1:0] ifetch_policy,
  output logic ifetch_l1_bypass,
  input wire logic data_req,
  input wire logic [`MMUT_VA_W-1:0] data_va,
  output logic data_ready,
  output logic data_rsp_valid,
  output logic [`MMUT_VA_W-1:0] data_pa,
  output logic [1:0] data_mem_type,
  output logic [1:0] data_share,
  output logic [1:0] data_policy,
  output logic data_l1_bypass,
  output logic data_write_alloc,
  input wire logic data_line_write,
  input wire logic data_other_write,
  input wire logic [`MMUT_TAG_W-1:0] cur_address_space_tag,
  input wire logic cur_security_state,
  input wire logic coherency_participation_bit,
  input wire logic [1:0] table_base_cacheable,
  input wire logic table_base_split,
  input wire logic dormant,
  input wire logic micro_flush,
  input wire logic main_invalidate,
  output logic walk_req,
  output logic [`MMUT_VA_W-1:0] walk_va,
  output logic walk_cacheable,
  input wire logic walk_ack,
  input wire logic [`MMUT_VPN_W-1:0] walk_ppn,
  input wire logic [1:0] walk_size,
  input wire logic walk_global,
  input wire logic [1:0] walk_mem_type,
  input wire logic [1:0] walk_share,
  input wire logic [1:0] walk_policy,
  input wire logic hitmap_wr,
  input wire logic [`MMUT_NUM_SIZES-1:0] hitmap_wdata,
  output logic [`MMUT_NUM_SIZES-1:0] hitmap_rdata
);
  localparam int EW = $bits(mmut_entry_t);
  localparam int SETS = MAIN_N / WAYS;

  function automatic logic [`MMUT_VPN_W-1:0] size_mask(logic [1:0] sz);
    case (sz)
      `MMUT_SZ_64K: size_mask = {`MMUT_VPN_W{1'b1}} << `MMUT_SH_64K;
      `MMUT_SZ_1M: size_mask = {`MMUT_VPN_W{1'b1}} << `MMUT_SH_1M;
      `MMUT_SZ_16M: size_mask = {`MMUT_VPN_W{1'b1}} << `MMUT_SH_16M;
      default: size_mask = {`MMUT_VPN_W{1'b1}} << `MMUT_SH_4K;
    endcase
  endfunction

  function automatic logic [SET_W-1:0] set_of(logic [`MMUT_VPN_W-1:0] vpn, logic [1:0] sz);
    logic [`MMUT_VPN_W-1:0] t;
    case (sz)
      `MMUT_SZ_64K: t = vpn >> `MMUT_SH_64K;
      `MMUT_SZ_1M: t = vpn >> `MMUT_SH_1M;
      `MMUT_SZ_16M: t = vpn >> `MMUT_SH_16M;
      default: t = vpn >> `MMUT_SH_4K;
    endcase
    set_of = t[SET_W-1:0];
  endfunction

  function automatic logic entry_match(mmut_entry_t en, logic [`MMUT_VPN_W-1:0] vpn,
                                       logic [`MMUT_TAG_W-1:0] tag, logic ns);
    logic [`MMUT_VPN_W-1:0] m;
    m = size_mask(en.size);
    entry_match = ((en.vpn & m) == (vpn & m)) && (en.ns == ns) && (en.glob || (en.tag == tag));
  endfunction

  // Searches the hitmap for the next stored size at or above the start size.
  function automatic logic [2:0] next_size(logic [`MMUT_NUM_SIZES-1:0] hm, logic [2:0] start);
    logic found;
    found = 1'b0;
    next_size = 3'h4;
    for (int i = 0; i < `MMUT_NUM_SIZES; i++) begin
      if (!found && (i >= int'(start)) && hm[i]) begin
        found = 1'b1;
        next_size = 3'(i);
      end
    end
  endfunction

  // Folds page table attributes into the reduced set the memory system supports.
  function automatic mmut_attr_t resolve(mmut_entry_t en, logic coh);
    mmut_attr_t a;
    a.mtype = en.mtype;
    a.share = en.share;
    a.pol = en.pol;
    a.bypass = 1'b0;
    if (en.mtype == `MMUT_MT_NORMAL) begin
      if (en.share == `MMUT_SHR_OUTER) begin
        a.share = `MMUT_SHR_INNER;
      end
      if (en.pol == `MMUT_POL_WT) begin
        a.pol = `MMUT_POL_NC;
      end else if (en.pol == `MMUT_POL_WBNA) begin
        a.pol = `MMUT_POL_WBWA;
      end
      if ((en.share != `MMUT_SHR_NONE) && (a.pol == `MMUT_POL_WBWA) && !coh) begin
        a.pol = `MMUT_POL_NC;
      end
      a.bypass = (a.share == `MMUT_SHR_NONE) && (a.pol == `MMUT_POL_NC);
    end
    resolve = a;
  endfunction

  // Side 0 is instruction fetch, side 1 is data.
  logic [1:0] req;
  logic [1:0][`MMUT_VA_W-1:0] va;
  logic [1:0][`MMUT_VPN_W-1:0] vpn;
  logic [1:0] hit;
  logic [1:0] miss;
  mmut_entry_t utlb_reg [2][UTLB_N];
  logic [1:0][UTLB_N-1:0] uvld_reg;
  logic [1:0][`MMUT_RR_W-1:0] rr_reg;
  mmut_entry_t sel [2];
  mmut_attr_t attr [2];
  logic [1:0][`MMUT_VA_W-1:0] pa;
  logic [1:0] rsp_valid_reg;
  logic [1:0][`MMUT_VA_W-1:0] pa_reg;
  mmut_attr_t attr_reg [2];
  logic [`MMUT_STREAK_W-1:0] streak_reg;
  logic wa_stop;
  logic wa_reg;

  mmut_state_t st_reg;
  mmut_state_t st_next;
  logic side_reg;
  logic [`MMUT_VA_W-1:0] va_reg;
  logic [1:0] probe_reg;
  logic [2:0] probe_next;
  mmut_entry_t fill_reg;
  mmut_entry_t fill_next;
  logic victim_reg;
  logic [MAIN_N-1:0] mvld_reg;
  logic [`MMUT_NUM_SIZES-1:0] hitmap_reg;
  logic [SET_W-1:0] cur_set;
  logic [SET_W-1:0] walk_set;
  logic [WAYS-1:0] way_hit;
  mmut_entry_t way_entry [WAYS];
  mmut_entry_t walk_entry;
  logic start;
  logic [2:0] first_size;
  logic [2:0] later_size;

  mmut_ram_if #(.DW(EW), .WAYS(WAYS), .SET_W(SET_W)) ram ();

  mmut_tlb_ram #(.DW(EW), .WAYS(WAYS), .SET_W(SET_W)) u_ram (
    .clk(clk),
    .ram(ram.mem)
  );

  assign req = {data_req, ifetch_req};
  assign va[0] = ifetch_va;
  assign va[1] = data_va;

  genvar s, e;
  generate
    for (s = 0; s < 2; s++) begin : g_side
      mmut_entry_t acc [UTLB_N+1];
      logic [UTLB_N-1:0] ehit;
      assign vpn[s] = va[s][`MMUT_VA_W-1:`MMUT_OFS_W];
      assign acc[0] = '0;
      for (e = 0; e < UTLB_N; e++) begin : g_ent
        assign ehit[e] = uvld_reg[s][e] && entry_match(utlb_reg[s][e], vpn[s], cur_address_space_tag,
                                                       cur_security_state);
        assign acc[e+1] = acc[e] | (ehit[e] ? utlb_reg[s][e] : '0);
      end
      assign sel[s] = acc[UTLB_N];
      assign hit[s] = req[s] && (|ehit) && !dormant;
      assign miss[s] = req[s] && !(|ehit) && !dormant;
      assign attr[s] = resolve(sel[s], coherency_participation_bit);
      assign pa[s] = {(sel[s].ppn & size_mask(sel[s].size)) | (vpn[s] & ~size_mask(sel[s].size)),
                      va[s][`MMUT_OFS_W-1:0]};
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          rsp_valid_reg[s] <= 1'b0;
          pa_reg[s] <= '0;
          attr_reg[s] <= '0;
          uvld_reg[s] <= '0;
          rr_reg[s] <= '0;
        end else begin
          rsp_valid_reg[s] <= hit[s];
          if (hit[s]) begin
            pa_reg[s] <= pa[s];
            attr_reg[s] <= attr[s];
          end
          if (micro_flush || main_invalidate) begin
            uvld_reg[s] <= '0;
          end else if ((st_reg == MMUT_FILL) && (side_reg == s[0])) begin
            uvld_reg[s][rr_reg[s]] <= 1'b1;
            rr_reg[s] <= (rr_reg[s] == `MMUT_RR_W'(UTLB_N - 1)) ? '0 : rr_reg[s] + 1'b1;
          end
        end
      end
      always_ff @(posedge clk) begin
        if ((st_reg == MMUT_FILL) && (side_reg == s[0])) begin
          utlb_reg[s][rr_reg[s]] <= fill_reg;
        end
      end
    end
  endgenerate

  // Data side write allocation hint with streaming detection.
  assign wa_stop = (streak_reg > `MMUT_STREAK_W'(`MMUT_WA_STREAK)) && (attr[1].share == `MMUT_SHR_NONE);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      streak_reg <= '0;
      wa_reg <= 1'b0;
    end else begin
      if (data_other_write) begin
        streak_reg <= '0;
      end else if (data_line_write && (streak_reg <= `MMUT_STREAK_W'(`MMUT_WA_STREAK))) begin
        streak_reg <= streak_reg + 1'b1;
      end
      if (hit[1]) begin
        wa_reg <= (attr[1].mtype == `MMUT_MT_NORMAL) && (attr[1].pol == `MMUT_POL_WBWA) && !wa_stop;
      end
    end
  end

  // Main TLB walk controller.
  assign start = (st_reg == MMUT_IDLE) && (|miss) && !main_invalidate;
  assign first_size = next_size(hitmap_reg, 3'h0);
  assign later_size = next_size(hitmap_reg, 3'(probe_reg) + 3'h1);
  assign cur_set = set_of(va_reg[`MMUT_VA_W-1:`MMUT_OFS_W], probe_reg);
  assign walk_set = set_of(va_reg[`MMUT_VA_W-1:`MMUT_OFS_W], walk_size);
  assign walk_entry = '{vpn: va_reg[`MMUT_VA_W-1:`MMUT_OFS_W], ppn: walk_ppn, size: walk_size,
                        tag: cur_address_space_tag, glob: walk_global, ns: cur_security_state,
                        mtype: walk_mem_type, share: walk_share, pol: walk_policy};

  generate
    for (s = 0; s < WAYS; s++) begin : g_way
      assign way_entry[s] = ram.rd_data[s*EW +: EW];
      assign way_hit[s] = mvld_reg[s*SETS + int'(cur_set)] && (way_entry[s].size == probe_reg) &&
                          entry_match(way_entry[s], va_reg[`MMUT_VA_W-1:`MMUT_OFS_W],
                                      cur_address_space_tag, cur_security_state);
    end
  endgenerate

  assign ram.rd_en = (st_reg == MMUT_READ);
  assign ram.rd_idx = cur_set;
  assign ram.wr_en = (st_reg == MMUT_WALK) && walk_ack && !main_invalidate;
  assign ram.wr_way = victim_reg;
  assign ram.wr_idx = walk_set;
  assign ram.wr_data = walk_entry;

  always_comb begin
    st_next = st_reg;
    probe_next = 3'(probe_reg);
    fill_next = fill_reg;
    case (st_reg)
      MMUT_IDLE: begin
        if (start) begin
          probe_next = first_size;
          st_next = first_size[2] ? MMUT_WALK : MMUT_READ;
        end
      end
      MMUT_READ: st_next = MMUT_CMP;
      MMUT_CMP: begin
        if (|way_hit) begin
          fill_next = way_hit[0] ? way_entry[0] : way_entry[1];
          st_next = MMUT_FILL;
        end else begin
          probe_next = later_size;
          st_next = later_size[2] ? MMUT_WALK : MMUT_READ;
        end
      end
      MMUT_WALK: begin
        if (walk_ack) begin
          fill_next = walk_entry;
          st_next = MMUT_FILL;
        end
      end
      MMUT_FILL: st_next = MMUT_IDLE;
      default: st_next = MMUT_IDLE;
    endcase
    if (main_invalidate) begin
      st_next = MMUT_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= MMUT_IDLE;
      side_reg <= 1'b0;
      va_reg <= '0;
      probe_reg <= '0;
      fill_reg <= '0;
      victim_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      probe_reg <= probe_next[1:0];
      fill_reg <= fill_next;
      if (start) begin
        side_reg <= miss[1];
        va_reg <= miss[1] ? va[1] : va[0];
      end
      if (ram.wr_en) begin
        victim_reg <= ~victim_reg;
      end
    end
  end

  // A fill that stores a new size sets its hitmap bit even when software writes in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mvld_reg <= '0;
      hitmap_reg <= '0;
    end else if (main_invalidate) begin
      mvld_reg <= '0;
      hitmap_reg <= '0;
    end else begin
      if (ram.wr_en) begin
        mvld_reg[int'(victim_reg) * SETS + int'(walk_set)] <= 1'b1;
      end
      hitmap_reg <= (hitmap_wr ? hitmap_wdata : hitmap_reg) |
                    (ram.wr_en ? (`MMUT_NUM_SIZES'(1) << walk_size) : '0);
    end
  end

  assign walk_req = (st_reg == MMUT_WALK);
  assign walk_va = va_reg;
  assign walk_cacheable = table_base_cacheable[table_base_split & va_reg[`MMUT_SPLIT_BIT]];
  assign hitmap_rdata = hitmap_reg;

  // Ready is combinational, so a first-level hit is taken in the cycle it is looked up.
  assign ifetch_ready = hit[0];
  assign data_ready = hit[1];
  assign ifetch_rsp_valid = rsp_valid_reg[0];
  assign ifetch_pa = pa_reg[0];
  assign ifetch_mem_type = attr_reg[0].mtype;
  assign ifetch_share = attr_reg[0].share;
  assign ifetch_policy = attr_reg[0].pol;
  assign ifetch_l1_bypass = attr_reg[0].bypass;
  assign data_rsp_valid = rsp_valid_reg[1];
  assign data_pa = pa_reg[1];
  assign data_mem_type = attr_reg[1].mtype;
  assign data_share = attr_reg[1].share;
  assign data_policy = attr_reg[1].pol;
  assign data_l1_bypass = attr_reg[1].bypass;
  assign data_write_alloc = wa_reg;
endmodule
`default_nettype wire

// *** mmut_tlb_props.sv ***
// Port-level assertions for the translation unit.
`include "mmut_params.svh"
`default_nettype none
module mmut_tlb_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ifetch_req,
  input wire logic ifetch_ready,
  input wire logic ifetch_rsp_valid,
  input wire logic data_req,
  input wire logic data_ready,
  input wire logic data_rsp_valid,
  input wire logic [1:0] data_mem_type,
  input wire logic [1:0] data_share,
  input wire logic [1:0] data_policy,
  input wire logic data_l1_bypass,
  input wire logic coherency_participation_bit,
  input wire logic dormant,
  input wire logic main_invalidate,
  input wire logic walk_req,
  input wire logic [`MMUT_VA_W-1:0] walk_va,
  input wire logic walk_cacheable,
  input wire logic walk_ack,
  input wire logic [1:0] table_base_cacheable,
  input wire logic table_base_split,
  input wire logic hitmap_wr,
  input wire logic [`MMUT_NUM_SIZES-1:0] hitmap_wdata,
  input wire logic [`MMUT_NUM_SIZES-1:0] hitmap_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_dacc;
    data_req && data_ready;
  endsequence
  sequence s_wdone;
    walk_req && walk_ack ##1 !walk_req;
  endsequence
  logic d_norm;
  assign d_norm = data_rsp_valid && data_mem_type == `MMUT_MT_NORMAL;
  AST_DATA_RSP: assert property (s_dacc |=> data_rsp_valid)
    else $error("data answer missing");
  AST_DATA_NORSP: assert property (!(data_req && data_ready) |=> !data_rsp_valid)
    else $error("stray data answer");
  AST_INSTR_RSP: assert property (ifetch_rsp_valid |-> $past(ifetch_req && ifetch_ready))
    else $error("instr answer");
  AST_DORMANT: assert property (dormant |-> !data_ready && !ifetch_ready)
    else $error("lookup while dormant");
  AST_WALK_HOLD: assert property (walk_req && !walk_ack && !main_invalidate |=> walk_req)
    else $error("walk dropped");
  AST_WALK_END: assert property (walk_req && walk_ack |-> s_wdone)
    else $error("walk not ended");
  AST_WALK_CACHE: assert property (walk_req |-> walk_cacheable ==
    ((table_base_split && walk_va[`MMUT_SPLIT_BIT]) ? table_base_cacheable[1] : table_base_cacheable[0]))
    else $error("walk cacheability wrong");
  AST_REDUCED: assert property (d_norm |-> data_share != `MMUT_SHR_OUTER &&
    data_policy != `MMUT_POL_WT && data_policy != `MMUT_POL_WBNA) else $error("unsupported attribute passed");
  AST_BYPASS: assert property (d_norm && data_share == `MMUT_SHR_NONE &&
    data_policy == `MMUT_POL_NC |-> data_l1_bypass) else $error("no bypass");
  AST_SHARED_NC: assert property (d_norm && data_share != `MMUT_SHR_NONE &&
    !$past(coherency_participation_bit) |-> data_policy == `MMUT_POL_NC) else $error("shared region cached");
  AST_HITMAP: assert property (hitmap_wr && !main_invalidate |=>
    (hitmap_rdata & $past(hitmap_wdata)) == $past(hitmap_wdata)) else $error("hitmap write lost");
endmodule
bind mmut_tlb mmut_tlb_props props (.*);
`default_nettype wire

// *** mmut_walker.sv ***
// Table walker model answering walk requests with descriptors decoded from the address.
`default_nettype none
module mmut_walker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic walk_req,
  input wire logic [31:0] walk_va,
  output logic walk_ack,
  output logic [19:0] walk_ppn,
  output logic [1:0] walk_size,
  output logic walk_global,
  output logic [1:0] walk_mem_type,
  output logic [1:0] walk_share,
  output logic [1:0] walk_policy,
  output int walks
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] wait_reg;
  logic [28:0] desc;
  assign desc = {walk_va[18], walk_va[17:12], walk_va[20:19], 4'h9, walk_va[27:12] ^ 16'h0fff};
  // Outside the ack cycle the fields show the inverse, so a design sampling late sees garbage.
  assign {walk_global, walk_mem_type, walk_share, walk_policy, walk_size, walk_ppn} = walk_ack ? desc : ~desc;
  // Alternate walks answer promptly and slowly.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 3'h0;
      walk_ack <= 1'b0;
      walks <= 0;
    end else if (walk_ack) begin
      walk_ack <= 1'b0;
      wait_reg <= 3'h0;
      walks <= walks + 1;
    end else if (walk_req) begin
      wait_reg <= wait_reg + 3'h1;
      walk_ack <= wait_reg == (walks[0] ? 3'h4 : 3'h1);
    end else begin
      wait_reg <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// *** mmut_tlb_bench.sv ***
// Self-checking bench for the translation unit.
`include "mmut_params.svh"
`default_nettype none
module mmut_tlb_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, resetn = 1'b0, ifetch_req = 1'b0, data_req = 1'b0;
  logic data_line_write = 1'b0, data_other_write = 1'b0, hitmap_wr = 1'b0;
  logic cur_security_state = 1'b0, coherency_participation_bit = 1'b0, table_base_split = 1'b0;
  logic dormant = 1'b0, micro_flush = 1'b0, main_invalidate = 1'b0;
  logic [31:0] ifetch_va = 32'h0000_0000, data_va = 32'h0000_0000;
  logic [7:0] cur_address_space_tag = 8'h00;
  logic [1:0] table_base_cacheable = 2'h0;
  logic [3:0] hitmap_wdata = 4'h0;
  logic ifetch_ready, ifetch_rsp_valid, ifetch_l1_bypass, data_ready, data_rsp_valid, data_l1_bypass;
  logic data_write_alloc, walk_req, walk_cacheable, walk_ack, walk_global;
  logic [31:0] ifetch_pa, data_pa, walk_va, r_pa;
  logic [1:0] ifetch_mem_type, ifetch_share, ifetch_policy, data_mem_type, data_share, data_policy;
  logic [1:0] walk_size, walk_mem_type, walk_share, walk_policy;
  logic [19:0] walk_ppn;
  logic [3:0] hitmap_rdata;
  logic [6:0] r_attr;
  logic r_wa;
  int walks, w;
  int err_count = 0;
  int n_checks = 0;
  mmut_tlb dut (.*);
  mmut_walker walker (.*);
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic pulse(ref logic sig, input int n);
    @(posedge clk);
    #1 sig = 1'b1;
    repeat (n) @(posedge clk);
    #1 sig = 1'b0;
  endtask
  function automatic logic [31:0] va_of(input logic [5:0] attr);
    return 32'h1004_0000 | {14'h0000, attr, 12'h000};
  endfunction
  function automatic logic [31:0] exp_pa(input logic [31:0] va);
    logic [31:0] base, mask;
    base = {4'h9, va[27:12] ^ 16'h0fff, 12'h000};
    mask = (32'h0000_0001 << (12 + 4 * va[20:19])) - 32'h0000_0001;
    return (base & ~mask) | (va & mask);
  endfunction
  function automatic logic [6:0] exp_attr(input logic [31:0] va, input logic coh);
    logic [1:0] mt, sh, p;
    mt = va[17:16];
    sh = va[15:14];
    p = va[13:12];
    if (mt != `MMUT_MT_NORMAL) return {mt, sh, p, 1'b0};
    if (sh == `MMUT_SHR_OUTER) sh = `MMUT_SHR_INNER;
    if (p == `MMUT_POL_WT) p = `MMUT_POL_NC;
    if (p == `MMUT_POL_WBNA) p = `MMUT_POL_WBWA;
    if (sh != `MMUT_SHR_NONE && !coh) p = `MMUT_POL_NC;
    return {mt, sh, p, sh == `MMUT_SHR_NONE && p == `MMUT_POL_NC};
  endfunction
  // The request is held until the edge that samples ready high; a miss may take a whole walk.
  task automatic lookup(input logic ins, input logic [31:0] va);
    int n;
    @(posedge clk);
    #1 ifetch_va = va;
    data_va = va;
    if (ins) ifetch_req = 1'b1;
    else data_req = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((ins ? ifetch_ready : data_ready) !== 1'b1 && n < 300);
    #1 ifetch_req = 1'b0;
    data_req = 1'b0;
    chk(32'(n < 300), 1);
    chk(ins ? ifetch_rsp_valid : data_rsp_valid, 1);
    r_pa = ins ? ifetch_pa : data_pa;
    r_attr = ins ? {ifetch_mem_type, ifetch_share, ifetch_policy, ifetch_l1_bypass} :
      {data_mem_type, data_share, data_policy, data_l1_bypass};
    r_wa = data_write_alloc;
  endtask
  task automatic chk_xlat(input logic [31:0] va);
    chk(r_pa, exp_pa(va));
    chk(r_attr, exp_attr(va, coherency_participation_bit));
  endtask
  task automatic t_attr();
    logic [31:0] va;
    for (int i = 0; i < 72; i++) begin
      va = va_of({2'((i % 36) / 12), 2'((i % 12) / 4), 2'(i % 4)});
      coherency_participation_bit = i >= 36;
      table_base_cacheable = 2'(i);
      table_base_split = i[2];
      lookup(1'b0, va);
      chk_xlat(va);
      lookup(1'b1, va);
      chk_xlat(va);
    end
    $display("attribute test done");
  endtask
  task automatic t_dormant();
    logic [31:0] va;
    va = va_of(6'b10_0110);
    pulse(micro_flush, 1);
    w = walks;
    dormant = 1'b1;
    fork
      lookup(1'b0, va);
      begin
        repeat (6) @(posedge clk);
        chk(data_ready, 0);
        #1 dormant = 1'b0;
      end
    join
    chk(walks, w);
    chk_xlat(va);
    $display("dormant test done");
  endtask
  task automatic t_sizes();
    logic [31:0] va;
    for (int s = 0; s < 4; s++) begin
      va = {4'h5, 2'b00, 2'(s), 3'h5, 2'(s), 1'b1, 6'b10_0010, 12'habc};
      lookup(1'b1, va);
      chk(r_pa, exp_pa(va));
    end
    chk(hitmap_rdata, 4'hf);
    $display("page size test done");
  endtask
  task automatic t_tags();
    table_base_cacheable = 2'h2;
    table_base_split = 1'b1;
    cur_address_space_tag = 8'h11;
    lookup(1'b0, 32'hb000_0000);
    w = walks;
    cur_address_space_tag = 8'h22;
    lookup(1'b0, 32'hb000_0000);
    chk(walks, w + 1);
    cur_address_space_tag = 8'h11;
    pulse(micro_flush, 1);
    lookup(1'b0, 32'hb000_0000);
    chk(walks, w + 1);
    lookup(1'b0, 32'h3004_0000);
    w = walks;
    cur_address_space_tag = 8'h33;
    lookup(1'b0, 32'h3004_0000);
    chk(walks, w);
    cur_security_state = 1'b1;
    lookup(1'b0, 32'h3004_0000);
    chk(walks, w + 1);
    cur_security_state = 1'b0;
    $display("tag test done");
  endtask
  task automatic t_streak();
    coherency_participation_bit = 1'b0;
    pulse(data_other_write, 1);
    pulse(data_line_write, 3);
    lookup(1'b0, va_of(6'b10_0010));
    chk(r_wa, 1);
    pulse(data_other_write, 1);
    pulse(data_line_write, 4);
    lookup(1'b0, va_of(6'b10_0010));
    chk(r_wa, 0);
    coherency_participation_bit = 1'b1;
    lookup(1'b0, va_of(6'b10_0110));
    chk(r_wa, 1);
    pulse(data_other_write, 1);
    lookup(1'b0, va_of(6'b10_0010));
    chk(r_wa, 1);
    $display("write streak test done");
  endtask
  task automatic t_hitmap();
    hitmap_wdata = 4'h5;
    pulse(hitmap_wr, 1);
    chk(hitmap_rdata, 4'h5);
    pulse(main_invalidate, 1);
    chk(hitmap_rdata, 4'h0);
    w = walks;
    lookup(1'b0, va_of(6'b10_0010));
    chk(walks, w + 1);
    $display("hitmap test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    t_attr();
    t_dormant();
    t_sizes();
    t_tags();
    t_streak();
    t_hitmap();
    stop_test();
  end
  // Expected run is well below this span, even with every lookup walking slowly.
  initial begin
    #1_000_000;
    $display("watchdog expired");
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
